// [logic/epo_pkg.sv]
// What this block does
// - Ampere-hour select steers rms current into apparent accumulators and converters.
// - Ampere-hour mode reuses the apparent gain, divider and pulse scaling registers.
// - Each converter emits one internal pulse per energy LSB when divider is 0 or 1.
// - Each output pulses once per denominator-to-numerator ratio of internal pulses.
// - Mode one bits 1 and 2 disable pulse outputs one and two.
// - Output one pulses set status bit 6, output two pulses set bit 7.
// - Enabled status bits 6 and 7 make the energy interrupt pending.
// - Source select 00 active, 01 reactive, 1X apparent or rms current.
// - One ampere-hour bit chooses apparent or rms current for both channels.
// - Output stays low 90 ms above 180 ms period, else 50 percent duty.
// - Zero scaling registers give the full converter rate, about 21.1 kHz.
// - Sixteen-bit unsigned numerator and denominator scale rate from 1/65535 to one.
// - A zero numerator or denominator acts as one.
// - A numerator above the denominator clamps the ratio to one.
// - The energy interrupt uses its own vector 0x004B.
// - Only events enabled in the mid enable register raise the interrupt; the low and high enables gate nothing here.
// - Interrupt stays active until its flag is cleared by writing zero.
// - A zero apparent divider divides the apparent accumulator by one.
package epo_pkg;

  // Clock and pulse timing.
  localparam int CLK_HZ          = 100_000_000;
  localparam int LOW_TIME_MS     = 90;
  localparam int PERIOD_LIMIT_MS = 180;
  localparam int LOW_CYCLES      = LOW_TIME_MS * (CLK_HZ / 1000);
  localparam int PERIOD_CYCLES   = PERIOD_LIMIT_MS * (CLK_HZ / 1000);
  localparam int TIME_W          = 25;

  // Register indices; the byte address is four times the index.
  localparam int ADDR_W                  = 10;
  localparam logic [7:0] IDX_MODE_ONE    = 8'h0B;
  localparam logic [7:0] IDX_MODE_TWO    = 8'h0C;
  localparam logic [7:0] IDX_APP_GAIN    = 8'h1F;
  localparam logic [7:0] IDX_APP_DIV     = 8'h26;
  localparam logic [7:0] IDX_P1_NUM      = 8'h27;
  localparam logic [7:0] IDX_P1_DEN      = 8'h28;
  localparam logic [7:0] IDX_P2_NUM      = 8'h29;
  localparam logic [7:0] IDX_P2_DEN      = 8'h2A;
  localparam logic [7:0] IDX_ACT_DIV     = 8'h30;
  localparam logic [7:0] IDX_EN_LOW      = 8'hD9;
  localparam logic [7:0] IDX_EN_MID      = 8'hDA;
  localparam logic [7:0] IDX_EN_HIGH     = 8'hDB;
  localparam logic [7:0] IDX_STATUS_MID  = 8'hDD;

  // Field positions.
  localparam int P1_DISABLE_BIT = 1;
  localparam int P2_DISABLE_BIT = 2;
  localparam int AMP_HOUR_BIT   = 3;
  localparam int P1_SRC_LSB     = 0;
  localparam int P2_SRC_LSB     = 4;
  localparam int P1_FLAG_BIT    = 6;
  localparam int P2_FLAG_BIT    = 7;
  localparam logic [7:0] STATUS_MID_MASK = 8'hC0;

  // Reset values and fixed codes.
  localparam logic [7:0]  RST_BYTE          = 8'h00;
  localparam logic [11:0] RST_GAIN          = 12'h000;
  localparam logic [15:0] RST_SCALE         = 16'h0000;
  localparam logic [15:0] ENERGY_IRQ_VECTOR = 16'h004B;

  // Accumulator LSB events from the energy datapath.
  typedef struct packed {
    logic active;
    logic reactive;
    logic apparent;
    logic irms;
  } energy_lsb_t;

  // Software-visible state of the block.
  typedef struct packed {
    logic [7:0]       mode_one;
    logic [7:0]       mode_two;
    logic [11:0]      apparent_gain;
    logic [7:0]       apparent_divider;
    logic [7:0]       active_energy_divider;
    logic [1:0][15:0] pulse_numerator;
    logic [1:0][15:0] pulse_denominator;
    logic [7:0]       irq_enable_low;
    logic [7:0]       irq_enable_mid;
    logic [7:0]       irq_enable_high;
    logic [7:0]       irq_status_mid;
    logic [31:0]      rdata;
  } regs_t;

endpackage

// [logic/pulse_scaler.sv]
`timescale 1ns/100ps
module pulse_scaler
  import epo_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         enable,
  input  wire logic         lsb_pulse,
  input  wire logic [7:0]   divider,
  input  wire logic [W-1:0] numerator,
  input  wire logic [W-1:0] denominator,
  output logic              out_pulse
);

  typedef struct packed {
    logic [7:0] pre;
    logic [W:0] acc;
    logic       out;
  } scaler_t;

  scaler_t     st;
  scaler_t     next_st;
  logic [W:0]  num_eff;
  logic [W:0]  den_eff;
  logic [W:0]  sum;
  logic        dfc;

  // Zero reads as one, and a ratio above one is clamped to one.
  always_comb begin
    den_eff = (denominator == '0) ? (W+1)'(1) : {1'b0, denominator};
    num_eff = (numerator == '0) ? (W+1)'(1) : {1'b0, numerator};
    if (num_eff > den_eff) begin
      num_eff = den_eff;
    end
  end

  // Internal converter pulse: every LSB unless the active divider asks for more.
  assign dfc = lsb_pulse && ((divider <= 8'h01) || (st.pre == divider - 8'h01));
  assign sum = st.acc + num_eff;

  // Fractional accumulator: output rate is input rate times num/den.
  always_comb begin
    next_st     = st;
    next_st.out = 1'b0;
    if (!enable) begin
      next_st = '0;
    end else if (dfc) begin
      next_st.pre = 8'h00;
      if (sum >= den_eff) begin
        next_st.acc = sum - den_eff;
        next_st.out = 1'b1;
      end else begin
        next_st.acc = sum;
      end
    end else if (lsb_pulse) begin
      next_st.pre = st.pre + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_pulse = st.out;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  unity_ratio_a: assert property ((enable && dfc && num_eff == den_eff) |=> out_pulse)
    else $error("Unity ratio did not pass a converter pulse.");
  no_spurious_a: assert property (out_pulse |-> $past(dfc) && $past(enable))
    else $error("Output pulse without a converter pulse.");

endmodule

// [logic/pulse_shaper.sv]
`timescale 1ns/100ps
module pulse_shaper
  import epo_pkg::*;
#(
  parameter int LOW_MAX    = LOW_CYCLES,
  parameter int PERIOD_MAX = PERIOD_CYCLES
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic fire,
  output logic      out_n
);

  typedef struct packed {
    logic [TIME_W-1:0] period;
    logic [TIME_W-1:0] low;
    logic              out_n;
  } shaper_t;

  localparam logic [TIME_W-1:0] LOW_LEN  = TIME_W'(LOW_MAX);
  localparam logic [TIME_W-1:0] PER_LEN  = TIME_W'(PERIOD_MAX);
  localparam logic [TIME_W-1:0] ONE      = TIME_W'(1);

  shaper_t st;
  shaper_t next_st;

  // Long periods give a fixed low time; short ones give half the last period.
  // The period counter starts saturated so the first pulse gets the full low time.
  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st.period = PER_LEN;
      next_st.low    = '0;
      next_st.out_n  = 1'b1;
    end else begin
      if (st.period < PER_LEN) begin
        next_st.period = st.period + ONE;
      end
      if (st.low != '0) begin
        next_st.low = st.low - ONE;
      end
      if (fire) begin
        next_st.period = '0;
        if (st.period >= PER_LEN) begin
          next_st.low = LOW_LEN;
        end else if (st.period != '0) begin
          // The counter holds one less than the edges between pulses, so add it back.
          next_st.low = (st.period + ONE) >> 1;
        end else begin
          next_st.low = ONE;
        end
      end
      next_st.out_n = (next_st.low == '0);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '{period: PER_LEN, low: '0, out_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign out_n = st.out_n;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  long_low_a: assert property ((enable && fire && st.period >= PER_LEN) |=> (st.low == LOW_LEN))
    else $error("Long-period pulse did not load the full low time.");
  fire_low_a: assert property ((enable && fire) |=> !out_n)
    else $error("Output not low after a pulse.");

endmodule

// [logic/energy_pulse_output_converter.sv]
`timescale 1ns/100ps
module energy_pulse_output_converter
  import epo_pkg::*;
#(
  parameter int LOW_MAX    = LOW_CYCLES,
  parameter int PERIOD_MAX = PERIOD_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire energy_lsb_t       energy_lsb,
  output logic                   amp_hour_active,
  output logic      [11:0]       apparent_gain_out,
  output logic      [7:0]        apparent_divisor,
  output logic                   pulse1_out_n,
  output logic                   pulse2_out_n,
  output logic                   energy_irq,
  output logic      [15:0]       energy_irq_vector
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state and APB decode.

  regs_t       st;
  regs_t       next_st;
  logic [7:0]  idx;
  logic        aligned;
  logic        hit;
  logic [31:0] rd_word;
  logic        setup_phase;
  logic        write_cycle;
  logic [1:0]  pulse_fire;
  logic [1:0]  pulse_out_n;
  logic [1:0]  chan_enable;
  logic [1:0]  chan_lsb;
  logic        apparent_path_lsb;

  assign idx         = paddr[ADDR_W-1:2];
  assign aligned     = (paddr[1:0] == 2'b00);
  assign setup_phase = psel && !penable;
  assign write_cycle = psel && penable && pwrite && hit;

  // Address decode; unmapped or misaligned addresses read zero and flag an error.
  always_comb begin
    hit     = aligned;
    rd_word = 32'h0000_0000;
    if (idx == IDX_MODE_ONE) begin
      rd_word = {24'h000000, st.mode_one};
    end else if (idx == IDX_MODE_TWO) begin
      rd_word = {24'h000000, st.mode_two};
    end else if (idx == IDX_APP_GAIN) begin
      rd_word = {20'h00000, st.apparent_gain};
    end else if (idx == IDX_APP_DIV) begin
      rd_word = {24'h000000, st.apparent_divider};
    end else if (idx == IDX_P1_NUM) begin
      rd_word = {16'h0000, st.pulse_numerator[0]};
    end else if (idx == IDX_P1_DEN) begin
      rd_word = {16'h0000, st.pulse_denominator[0]};
    end else if (idx == IDX_P2_NUM) begin
      rd_word = {16'h0000, st.pulse_numerator[1]};
    end else if (idx == IDX_P2_DEN) begin
      rd_word = {16'h0000, st.pulse_denominator[1]};
    end else if (idx == IDX_ACT_DIV) begin
      rd_word = {24'h000000, st.active_energy_divider};
    end else if (idx == IDX_EN_LOW) begin
      rd_word = {24'h000000, st.irq_enable_low};
    end else if (idx == IDX_EN_MID) begin
      rd_word = {24'h000000, st.irq_enable_mid};
    end else if (idx == IDX_EN_HIGH) begin
      rd_word = {24'h000000, st.irq_enable_high};
    end else if (idx == IDX_STATUS_MID) begin
      rd_word = {24'h000000, st.irq_status_mid};
    end else begin
      hit = 1'b0;
    end
    if (!aligned) begin
      rd_word = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for all registers.

  // Writes land at the access edge. Status flags clear by writing zero, and a
  // pulse in the same cycle wins so no calibration pulse is ever lost.
  always_comb begin
    next_st = st;
    if (setup_phase) begin
      next_st.rdata = rd_word;
    end
    if (write_cycle) begin
      if (idx == IDX_MODE_ONE) begin
        next_st.mode_one = pwdata[7:0];
      end else if (idx == IDX_MODE_TWO) begin
        next_st.mode_two = pwdata[7:0];
      end else if (idx == IDX_APP_GAIN) begin
        next_st.apparent_gain = pwdata[11:0];
      end else if (idx == IDX_APP_DIV) begin
        next_st.apparent_divider = pwdata[7:0];
      end else if (idx == IDX_P1_NUM) begin
        next_st.pulse_numerator[0] = pwdata[15:0];
      end else if (idx == IDX_P1_DEN) begin
        next_st.pulse_denominator[0] = pwdata[15:0];
      end else if (idx == IDX_P2_NUM) begin
        next_st.pulse_numerator[1] = pwdata[15:0];
      end else if (idx == IDX_P2_DEN) begin
        next_st.pulse_denominator[1] = pwdata[15:0];
      end else if (idx == IDX_ACT_DIV) begin
        next_st.active_energy_divider = pwdata[7:0];
      end else if (idx == IDX_EN_LOW) begin
        next_st.irq_enable_low = pwdata[7:0];
      end else if (idx == IDX_EN_MID) begin
        next_st.irq_enable_mid = pwdata[7:0];
      end else if (idx == IDX_EN_HIGH) begin
        next_st.irq_enable_high = pwdata[7:0];
      end else if (idx == IDX_STATUS_MID) begin
        next_st.irq_status_mid = st.irq_status_mid & pwdata[7:0];
      end
    end
    next_st.irq_status_mid[P1_FLAG_BIT] = next_st.irq_status_mid[P1_FLAG_BIT] | pulse_fire[0];
    next_st.irq_status_mid[P2_FLAG_BIT] = next_st.irq_status_mid[P2_FLAG_BIT] | pulse_fire[1];
    next_st.irq_status_mid = next_st.irq_status_mid & STATUS_MID_MASK;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '{mode_one: RST_BYTE, mode_two: RST_BYTE, apparent_gain: RST_GAIN,
              apparent_divider: RST_BYTE, active_energy_divider: RST_BYTE,
              pulse_numerator: {RST_SCALE, RST_SCALE}, pulse_denominator: {RST_SCALE, RST_SCALE},
              irq_enable_low: RST_BYTE, irq_enable_mid: RST_BYTE, irq_enable_high: RST_BYTE,
              irq_status_mid: RST_BYTE, rdata: 32'h0000_0000};
    end else begin
      st <= next_st;
    end
  end

  // The slave never inserts wait states; read data was captured in setup.
  assign pready  = 1'b1;
  assign prdata  = st.rdata;
  assign pslverr = psel && penable && !hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection and ampere-hour steering.

  // One shared bit picks rms current for the apparent path, so the two
  // channels can never mix apparent power and rms current.
  assign amp_hour_active   = st.mode_two[AMP_HOUR_BIT];
  assign apparent_path_lsb = amp_hour_active ? energy_lsb.irms : energy_lsb.apparent;

  // The apparent gain and divider serve both modes; software reloads them.
  assign apparent_gain_out = st.apparent_gain;
  assign apparent_divisor  = (st.apparent_divider == 8'h00) ? 8'h01 : st.apparent_divider;

  assign chan_enable[0] = !st.mode_one[P1_DISABLE_BIT];
  assign chan_enable[1] = !st.mode_one[P2_DISABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Two converter channels.

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      logic [1:0] src;

      assign src = (ch == 0) ? st.mode_two[P1_SRC_LSB +: 2] : st.mode_two[P2_SRC_LSB +: 2];

      // Source mux: 00 active, 01 reactive, 1X apparent path.
      always_comb begin
        case (src)
          2'b00:   chan_lsb[ch] = energy_lsb.active;
          2'b01:   chan_lsb[ch] = energy_lsb.reactive;
          default: chan_lsb[ch] = apparent_path_lsb;
        endcase
      end

      // Scaling registers at zero pass every converter pulse, the top rate.
      pulse_scaler #(
        .W (16)
      ) u_scaler (
        .mclk        (mclk),
        .reset       (reset),
        .enable      (chan_enable[ch]),
        .lsb_pulse   (chan_lsb[ch]),
        .divider     (st.active_energy_divider),
        .numerator   (st.pulse_numerator[ch]),
        .denominator (st.pulse_denominator[ch]),
        .out_pulse   (pulse_fire[ch])
      );

      pulse_shaper #(
        .LOW_MAX    (LOW_MAX),
        .PERIOD_MAX (PERIOD_MAX)
      ) u_shaper (
        .mclk   (mclk),
        .reset  (reset),
        .enable (chan_enable[ch]),
        .fire   (pulse_fire[ch]),
        .out_n  (pulse_out_n[ch])
      );
    end
  endgenerate

  assign pulse1_out_n = pulse_out_n[0];
  assign pulse2_out_n = pulse_out_n[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt.

  // Only the pulse flags live here; other enable bits gate events elsewhere.
  assign energy_irq        = |(st.irq_status_mid & st.irq_enable_mid);
  assign energy_irq_vector = ENERGY_IRQ_VECTOR;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_clear_flag1;
    write_cycle && idx == IDX_STATUS_MID && !pwdata[P1_FLAG_BIT] && !pulse_fire[0];
  endsequence

  sequence s_flag1_low;
    !st.irq_status_mid[P1_FLAG_BIT];
  endsequence

  flag_set_a: assert property (pulse_fire[0] |=> st.irq_status_mid[P1_FLAG_BIT])
    else $error("Pulse one did not set its flag.");
  flag_clear_a: assert property (s_clear_flag1 |=> s_flag1_low)
    else $error("Writing zero did not clear flag one.");
  irq_gate_a: assert property (energy_irq |->
                               (st.irq_status_mid[P1_FLAG_BIT] && st.irq_enable_mid[P1_FLAG_BIT]) ||
                               (st.irq_status_mid[P2_FLAG_BIT] && st.irq_enable_mid[P2_FLAG_BIT]))
    else $error("Interrupt raised by a disabled event.");
  irq_hold_a: assert property ((energy_irq && !write_cycle) |=> energy_irq)
    else $error("Interrupt dropped without a clear.");
  irq_flag2_a: assert property ((st.irq_status_mid[P2_FLAG_BIT] && st.irq_enable_mid[P2_FLAG_BIT]) |-> energy_irq)
    else $error("Enabled flag two did not raise the interrupt.");
  disabled_high_a: assert property (st.mode_one[P1_DISABLE_BIT] [*2] |-> pulse1_out_n)
    else $error("Disabled output one went low.");
  amp_hour_mux_a: assert property ((amp_hour_active && st.mode_two[P1_SRC_LSB+1] && !st.mode_one[P1_DISABLE_BIT])
                                   |-> chan_lsb[0] == energy_lsb.irms)
    else $error("Ampere-hour mode did not route rms current.");
  divisor_one_a: assert property (st.apparent_divider == 8'h00 |-> apparent_divisor == 8'h01)
    else $error("Zero apparent divider not treated as one.");

endmodule

// [bench/cal_counter.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Calibration counter on one pulse output: counts pulses, times the low phase.
module cal_counter (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic pulse_n,
  output int        count,
  output int        low_len
);
  int   run;
  logic prev;

  // A pulse counts on its falling edge, since only the low phase lights the lamp.
  // The low time is sampled in whole clocks, so it is exact only for clocked outputs.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      count   <= 0;
      low_len <= 0;
      run     <= 0;
      prev    <= 1'b1;
    end else begin
      prev <= pulse_n;
      if (prev && !pulse_n) count <= count + 1;
      if (!pulse_n) run <= run + 1;
      else if (!prev) begin
        low_len <= run;
        run     <= 0;
      end
    end
  end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  import epo_pkg::*;
  localparam int LOW_SIM = 20;
  localparam int PER_SIM = 40;
  logic              mclk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic              amp_hour_active, pulse1_out_n, pulse2_out_n, energy_irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, num;
  logic [11:0]       gain_out;
  logic [7:0]        divisor;
  logic [15:0]       vec;
  energy_lsb_t       lsb_in;
  int                cnt1, cnt2, low1, low2, mismatches, tests_run, seed, want, b1, b2;
  int                n[2], d[2], acc[2], exp_cnt[2], base[2];
  logic [7:0]        idxs[$] = '{IDX_MODE_ONE, IDX_MODE_TWO, IDX_APP_GAIN, IDX_APP_DIV, IDX_P1_NUM, IDX_P1_DEN,
                                 IDX_P2_NUM, IDX_P2_DEN, IDX_ACT_DIV, IDX_EN_LOW, IDX_EN_MID, IDX_EN_HIGH,
                                 IDX_STATUS_MID};

  energy_pulse_output_converter #(.LOW_MAX(LOW_SIM), .PERIOD_MAX(PER_SIM)) DUT (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .energy_lsb(lsb_in),
    .amp_hour_active(amp_hour_active), .apparent_gain_out(gain_out), .apparent_divisor(divisor),
    .pulse1_out_n(pulse1_out_n), .pulse2_out_n(pulse2_out_n), .energy_irq(energy_irq),
    .energy_irq_vector(vec));
  cal_counter cal1 (.mclk(mclk), .reset(reset), .pulse_n(pulse1_out_n), .count(cnt1), .low_len(low1));
  cal_counter cal2 (.mclk(mclk), .reset(reset), .pulse_n(pulse2_out_n), .count(cnt2), .low_len(low2));

  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  // One comparison, reported at once when it misses.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // APB transfer; waits on pready rather than assuming zero wait states.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk);
  endtask

  // One-cycle energy LSB strobe, then a quiet gap so the pulse can finish.
  task automatic fire(input energy_lsb_t b, input int gap);
    @(posedge mclk);
    lsb_in <= b;
    @(posedge mclk);
    lsb_in <= '0;
    repeat (gap) @(posedge mclk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lsb_in = '0;
    seed = 32'hB201E224;
    mismatches = 0;
    tests_run = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    foreach (idxs[i]) begin
      apb(1'b0, idxs[i], 32'h0);
      chk(rd, 32'h0, "reset value");
      chk({31'h0, err}, 32'h0, "mapped error");
    end
    apb(1'b0, 8'h00, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk({16'h0, vec}, 32'h0000004B, "vector");
    apb(1'b1, IDX_APP_GAIN, 32'h00000ABC);
    chk({20'h0, gain_out}, 32'h00000ABC, "gain");
    apb(1'b1, IDX_APP_DIV, 32'h0);
    chk({24'h0, divisor}, 32'h1, "divisor zero");
    $display("test registers done");
    // Random ratios, model is an exact fractional accumulator restarted by re-enable.
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, IDX_MODE_ONE, 32'h06);
      apb(1'b1, IDX_MODE_TWO, 32'h0);
      for (int c = 0; c < 2; c++) begin
        num = 32'($unsigned($random(seed)) % 8);
        apb(1'b1, IDX_P1_NUM + 8'(2 * c), num);
        apb(1'b0, IDX_P1_NUM + 8'(2 * c), 32'h0);
        chk(rd, num, "numerator readback");
        n[c] = (num == 0) ? 1 : int'(num);
        num = 32'($unsigned($random(seed)) % 8);
        apb(1'b1, IDX_P1_DEN + 8'(2 * c), num);
        d[c] = (num == 0) ? 1 : int'(num);
        if (n[c] > d[c]) n[c] = d[c];
        acc[c] = 0;
        exp_cnt[c] = 0;
      end
      base[0] = cnt1;
      base[1] = cnt2;
      apb(1'b1, IDX_MODE_ONE, 32'h0);
      for (int k = 0; k < 12; k++) begin
        fire(4'b1000, 45);
        for (int c = 0; c < 2; c++) begin
          acc[c] += n[c];
          if (acc[c] >= d[c]) begin
            acc[c] -= d[c];
            exp_cnt[c]++;
          end
        end
      end
      chk(32'(cnt1 - base[0]), 32'(exp_cnt[0]), "ch1 scaled count");
      chk(32'(cnt2 - base[1]), 32'(exp_cnt[1]), "ch2 scaled count");
    end
    $display("test scaling done");
    // Every source code under both ampere-hour settings, unity ratio.
    for (int i = 8'h27; i <= 8'h2A; i++) apb(1'b1, 8'(i), 32'h0);
    for (int ah = 0; ah < 2; ah++) begin
      for (int sel = 0; sel < 4; sel++) begin
        apb(1'b1, IDX_MODE_TWO, 32'((ah << 3) | (sel << 4) | sel));
        chk({31'h0, amp_hour_active}, 32'(ah), "amp hour flag");
        for (int k = 0; k < 4; k++) begin
          b1 = cnt1;
          b2 = cnt2;
          fire(energy_lsb_t'(4'b0001 << k), 45);
          want = (sel == 0) ? 3 : (sel == 1) ? 2 : (ah == 1) ? 0 : 1;
          chk(32'(cnt1 - b1), 32'(k == want), "ch1 source");
          chk(32'(cnt2 - b2), 32'(k == want), "ch2 source");
        end
      end
    end
    $display("test sources done");
    // Disabled output idles high and counts nothing.
    apb(1'b1, IDX_MODE_TWO, 32'h0);
    apb(1'b1, IDX_MODE_ONE, 32'h02);
    b1 = cnt1;
    b2 = cnt2;
    repeat (3) fire(4'b1000, 45);
    chk(32'(cnt1 - b1), 32'h0, "ch1 disabled");
    chk({31'h0, pulse1_out_n}, 32'h1, "ch1 idle");
    chk(32'(cnt2 - b2), 32'h3, "ch2 enabled");
    apb(1'b1, IDX_MODE_ONE, 32'h04);
    fire(4'b1000, 45);
    chk(32'(cnt1 - b1), 32'h1, "ch1 reenabled");
    chk(32'(cnt2 - b2), 32'h3, "ch2 disabled");
    apb(1'b1, IDX_MODE_ONE, 32'h0);
    $display("test disable done");
    // Long period gives the fixed low time, short period half the period.
    fire(4'b1000, 58);
    fire(4'b1000, 58);
    chk(32'(low1), 32'(LOW_SIM), "long low");
    // Two short gaps in a row, so the last pulse follows a 30-cycle period.
    repeat (2) fire(4'b1000, 28);
    chk(32'(low1), 32'(30 / 2), "half duty");
    $display("test width done");
    // Flags, masking and write-zero clearing.
    apb(1'b1, IDX_STATUS_MID, 32'h0);
    apb(1'b1, IDX_EN_MID, 32'h0);
    apb(1'b1, IDX_EN_LOW, 32'hFF);
    apb(1'b1, IDX_EN_HIGH, 32'hFF);
    fire(4'b1000, 45);
    apb(1'b0, IDX_STATUS_MID, 32'h0);
    chk(rd, 32'hC0, "flags set");
    chk({31'h0, energy_irq}, 32'h0, "masked");
    apb(1'b1, IDX_EN_MID, 32'h40);
    chk({31'h0, energy_irq}, 32'h1, "ch1 irq");
    apb(1'b1, IDX_STATUS_MID, 32'h80);
    apb(1'b0, IDX_STATUS_MID, 32'h0);
    chk(rd, 32'h80, "clear bit six");
    chk({31'h0, energy_irq}, 32'h0, "irq dropped");
    apb(1'b1, IDX_EN_MID, 32'h80);
    chk({31'h0, energy_irq}, 32'h1, "ch2 irq");
    apb(1'b1, IDX_STATUS_MID, 32'h0);
    chk({31'h0, energy_irq}, 32'h0, "irq cleared");
    $display("test interrupts done");
    test_done();
  end
endmodule
